// File: design/tsisp_i2c_slave.sv
/*
  tsisp_i2c_slave: i2c target port giving an external controller access to
  the 8-bit internal registers of the touch sensor.
  assumes scl, sda and the address strap are asynchronous pins; the register
  bank sits on clk and answers reg_rd_data combinationally from reg_rd_addr.
*/
// Summary of operation
// - sda changes only while scl low, except start and stop.
// - each byte is eight data bits plus one acknowledge bit.
// - receiver drives ack low on success, leaves it high otherwise.
// - first byte after start is the address; act only on a match.
// - strap selects address byte 0xd0 (low) or 0xf0 (high).
// - direction bit after address: zero is write, one is read.
// - first write byte after the address loads the register pointer.
// - later write bytes store at the pointer, then pointer advances.
// - sequential write data accepted until the controller issues stop.
// - every received byte in a write is acknowledged.
// - pointer set by data-less write is kept after the stop.
// - read returns data from held pointer, advancing after each byte.
`timescale 1ns/1ps

module tsisp_i2c_slave (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  input  wire logic                 address_select_pin,
  output logic                      reg_wr_en,
  output tsisp_pkg::tsisp_wr_t      reg_wr,
  output logic [7:0]                reg_rd_addr,
  input  wire logic [7:0]           reg_rd_data,
  output logic                      bus_active
);

  tsisp_pkg::tsisp_regs_t s_q;
  tsisp_pkg::tsisp_regs_t s_d;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic sda_now;

  always_comb begin
    s_d = s_q;
    // synchronisers: first stage feeds only the second
    s_d.line_s1 = {scl_i, sda_i};
    s_d.line_s2 = s_q.line_s1;
    s_d.sel_s1  = address_select_pin;
    s_d.sel_s2  = s_q.sel_s1;

    // sync plus filter delay must stay well under the scl low time
    // spike filter: a level must stand SPIKE_CYC cycles to be taken
    s_d.line_p = s_q.line_f;
    for (int i = 0; i < 2; i++) begin
      if (s_q.line_s2[i] != s_q.line_f[i]) begin
        if (s_q.filt_cnt[i] >= tsisp_pkg::SPIKE_CYC - 4'h1) begin
          s_d.line_f[i]   = s_q.line_s2[i];
          s_d.filt_cnt[i] = 4'h0;
        end else begin
          s_d.filt_cnt[i] = s_q.filt_cnt[i] + 4'h1;
        end
      end else begin
        s_d.filt_cnt[i] = 4'h0;
      end
    end

    // strap read continuously: moving it mid transfer changes the address
    // strap picks the target address
    s_d.own_addr = s_q.sel_s2 ? tsisp_pkg::TADDR_SEL_HIGH : tsisp_pkg::TADDR_SEL_LOW;

    scl_rise = s_q.line_f[tsisp_pkg::LINE_SCL] & ~s_q.line_p[tsisp_pkg::LINE_SCL];
    scl_fall = ~s_q.line_f[tsisp_pkg::LINE_SCL] & s_q.line_p[tsisp_pkg::LINE_SCL];
    sda_now  = s_q.line_f[tsisp_pkg::LINE_SDA];
    // sda edges while scl high are start or stop only
    start_cond = s_q.line_f[tsisp_pkg::LINE_SCL] & s_q.line_p[tsisp_pkg::LINE_SCL]
               & s_q.line_p[tsisp_pkg::LINE_SDA] & ~sda_now;
    stop_cond  = s_q.line_f[tsisp_pkg::LINE_SCL] & s_q.line_p[tsisp_pkg::LINE_SCL]
               & ~s_q.line_p[tsisp_pkg::LINE_SDA] & sda_now;

    s_d.wr_en = 1'b0;
    // open drain: only the enable moves, the level stays low
    s_d.sda_o = tsisp_pkg::ACK_LEVEL;

    // start and stop win over any bit event in the same cycle
    if (start_cond) begin
      s_d.st      = tsisp_pkg::TSISP_ST_RECV;
      s_d.ph      = tsisp_pkg::TSISP_PH_ADDR;
      s_d.bit_cnt = 4'h0;
      s_d.sda_oe  = 1'b0;
      s_d.active  = 1'b0;
    end else if (stop_cond) begin
      // stop ends the transfer but keeps the pointer
      s_d.st     = tsisp_pkg::TSISP_ST_IDLE;
      s_d.sda_oe = 1'b0;
      s_d.active = 1'b0;
    end else begin
      unique case (s_q.st)
        tsisp_pkg::TSISP_ST_IDLE: begin
          s_d.sda_oe = 1'b0;
        end
        tsisp_pkg::TSISP_ST_RECV: begin
          // eight bits sampled on scl rising
          if (scl_rise && s_q.bit_cnt < tsisp_pkg::BITS_PER_BYTE) begin
            s_d.shreg   = {s_q.shreg[6:0], sda_now};
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
          if (scl_fall && s_q.bit_cnt == tsisp_pkg::BITS_PER_BYTE) begin
            unique case (s_q.ph)
              tsisp_pkg::TSISP_PH_ADDR: begin
                // act only on our own address
                if (s_q.shreg[7:1] == s_q.own_addr) begin
                  s_d.rw     = s_q.shreg[0];
                  s_d.active = 1'b1;
                  s_d.sda_oe = 1'b1;
                  s_d.st     = tsisp_pkg::TSISP_ST_ACK;
                end else begin
                  // no ack, release, wait for a start
                  s_d.sda_oe = 1'b0;
                  s_d.st     = tsisp_pkg::TSISP_ST_IDLE;
                end
              end
              tsisp_pkg::TSISP_PH_PTR: begin
                // second write byte loads the pointer
                s_d.ptr    = s_q.shreg;
                s_d.ph     = tsisp_pkg::TSISP_PH_DATA;
                s_d.sda_oe = 1'b1;
                s_d.st     = tsisp_pkg::TSISP_ST_ACK;
              end
              tsisp_pkg::TSISP_PH_DATA: begin
                // data never refused: no nack on data bytes
                // store at pointer, then advance
                s_d.wr_en   = 1'b1;
                s_d.wr.addr = s_q.ptr;
                s_d.wr.data = s_q.shreg;
                s_d.ptr     = s_q.ptr + 8'h01;
                // good byte answered with a low ack
                s_d.sda_oe  = 1'b1;
                s_d.st      = tsisp_pkg::TSISP_ST_ACK;
              end
            endcase
          end
        end
        tsisp_pkg::TSISP_ST_ACK: begin
          // ack released only after scl falls
          if (scl_fall) begin
            s_d.bit_cnt = 4'h0;
            if (s_q.ph == tsisp_pkg::TSISP_PH_ADDR && s_q.rw == tsisp_pkg::DIR_READ) begin
              // reg_rd_data must already follow the pointer here
              // first read byte from the held pointer
              s_d.shreg  = reg_rd_data;
              s_d.sda_oe = ~reg_rd_data[7];
              s_d.ptr    = s_q.ptr + 8'h01;
              s_d.st     = tsisp_pkg::TSISP_ST_SEND;
            end else begin
              s_d.sda_oe = 1'b0;
              if (s_q.ph == tsisp_pkg::TSISP_PH_ADDR) begin
                s_d.ph = tsisp_pkg::TSISP_PH_PTR;
              end
              s_d.st = tsisp_pkg::TSISP_ST_RECV;
            end
          end
        end
        tsisp_pkg::TSISP_ST_SEND: begin
          if (scl_rise) begin
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
          // next data bit set up while scl low
          if (scl_fall) begin
            if (s_q.bit_cnt == tsisp_pkg::BITS_PER_BYTE) begin
              s_d.sda_oe = 1'b0;
              s_d.st     = tsisp_pkg::TSISP_ST_RACK;
            end else begin
              s_d.shreg  = {s_q.shreg[6:0], 1'b0};
              s_d.sda_oe = ~s_q.shreg[6];
            end
          end
        end
        tsisp_pkg::TSISP_ST_RACK: begin
          // high ack from the controller ends the read
          if (scl_rise && sda_now != tsisp_pkg::ACK_LEVEL) begin
            s_d.st = tsisp_pkg::TSISP_ST_IDLE;
          end else if (scl_fall) begin
            // next byte, pointer advances after each
            s_d.bit_cnt = 4'h0;
            s_d.shreg   = reg_rd_data;
            s_d.sda_oe  = ~reg_rd_data[7];
            s_d.ptr     = s_q.ptr + 8'h01;
            s_d.st      = tsisp_pkg::TSISP_ST_SEND;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= tsisp_pkg::TSISP_REGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign sda_o       = s_q.sda_o;
  assign sda_oe      = s_q.sda_oe;
  assign reg_wr_en   = s_q.wr_en;
  assign reg_wr      = s_q.wr;
  assign reg_rd_addr = s_q.ptr;
  assign bus_active  = s_q.active;

endmodule

// File: design/tsisp_pkg.sv
/*
  tsisp_pkg: constants and types for the touch sensor i2c target port.
  assumes one 200 mhz core clock and an i2c controller on scl/sda.
*/
package tsisp_pkg;

  // core clock and line filter timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SPIKE_MAX_NS  = 50;
  localparam logic [3:0]  SPIKE_CYC     = 4'((SPIKE_MAX_NS * 1000) / CLK_PERIOD_PS);

  // byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic       ACK_LEVEL     = 1'b0;
  localparam logic       DIR_READ      = 1'b1;

  // 7-bit target addresses chosen by the strap (0xd0 / 0xf0 with direction bit)
  localparam logic [6:0] TADDR_SEL_LOW  = 7'h68;
  localparam logic [6:0] TADDR_SEL_HIGH = 7'h78;

  // line vector positions
  localparam int unsigned LINE_SCL = 1;
  localparam int unsigned LINE_SDA = 0;

  localparam logic [7:0] PTR_RESET = 8'h00;

  typedef enum logic [4:0] {
    TSISP_ST_IDLE = 5'b00001,
    TSISP_ST_RECV = 5'b00010,
    TSISP_ST_ACK  = 5'b00100,
    TSISP_ST_SEND = 5'b01000,
    TSISP_ST_RACK = 5'b10000
  } tsisp_state_t;

  typedef enum logic [2:0] {
    TSISP_PH_ADDR = 3'b001,
    TSISP_PH_PTR  = 3'b010,
    TSISP_PH_DATA = 3'b100
  } tsisp_phase_t;

  // one register write toward the register bank
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } tsisp_wr_t;

  typedef struct packed {
    logic [1:0]      line_s1;
    logic [1:0]      line_s2;
    logic            sel_s1;
    logic            sel_s2;
    logic [1:0]      line_f;
    logic [1:0]      line_p;
    logic [1:0][3:0] filt_cnt;
    logic [6:0]      own_addr;
    tsisp_state_t    st;
    tsisp_phase_t    ph;
    logic [3:0]      bit_cnt;
    logic [7:0]      shreg;
    logic            rw;
    logic [7:0]      ptr;
    logic            sda_oe;
    logic            sda_o;
    logic            wr_en;
    tsisp_wr_t       wr;
    logic            active;
  } tsisp_regs_t;

  localparam tsisp_regs_t TSISP_REGS_RST = '{
    line_s1:  2'h3,
    line_s2:  2'h3,
    sel_s1:   1'b0,
    sel_s2:   1'b0,
    line_f:   2'h3,
    line_p:   2'h3,
    filt_cnt: '0,
    own_addr: TADDR_SEL_LOW,
    st:       TSISP_ST_IDLE,
    ph:       TSISP_PH_ADDR,
    bit_cnt:  4'h0,
    shreg:    8'h00,
    rw:       1'b0,
    ptr:      PTR_RESET,
    sda_oe:   1'b0,
    sda_o:    1'b0,
    wr_en:    1'b0,
    wr:       '0,
    active:   1'b0
  };

endpackage

// File: test/touch_sensor_i2c_slave_port_bench.sv
/*
  touch_sensor_i2c_slave_port_bench: self-checking bench for the i2c target.
  assumes tsisp_host_model as controller and a plain bank as register file.
*/
`timescale 1ns/1ps
module touch_sensor_i2c_slave_port_bench;
  logic                 clk;
  logic                 rst;
  logic                 sel;
  logic                 scl;
  logic                 host_pull;
  logic                 sda_o;
  logic                 sda_oe;
  logic                 wr_en;
  tsisp_pkg::tsisp_wr_t wr;
  logic [7:0]           rd_addr;
  logic                 active;
  logic [7:0]           bank [256];
  int                   n_errors = 0;
  int                   num_checks = 0;
  // open drain with pull-up
  wire sda_w = (sda_oe ? sda_o : 1'b1) & !host_pull;
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (wr_en) bank[wr.addr] <= wr.data;
  tsisp_i2c_slave dut_u (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .address_select_pin(sel), .reg_wr_en(wr_en), .reg_wr(wr),
    .reg_rd_addr(rd_addr), .reg_rd_data(bank[rd_addr]), .bus_active(active));
  tsisp_host_model host_u (.clk(clk), .sda(sda_w), .scl(scl), .sda_pull(host_pull));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_b(input logic [7:0] d, input logic ack);
    logic a;
    host_u.wbyte(d, a);
    chk("ack", {7'h00, ack}, {7'h00, a});
  endtask
  task automatic rd_b(input logic more, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rbyte(more, d);
    chk("read", exp, d);
  endtask
  // offset and init value of general_control_two; upper bits are reserved
  localparam logic [7:0] GCTL2_ADDR = 8'h09;
  localparam logic [7:0] GCTL2_INIT = 8'h03;
  task automatic t_init();
    host_u.start();
    wr_b(8'hd0, 1'b0);
    wr_b(GCTL2_ADDR, 1'b0);
    wr_b(GCTL2_INIT, 1'b0);
    host_u.stop();
    chk("general_control_two", GCTL2_INIT, bank[GCTL2_ADDR]);
  endtask
  task automatic t_write();
    host_u.start();
    wr_b(8'hd0, 1'b0);
    chk("active", 8'h01, {7'h00, active});
    wr_b(8'h05, 1'b0);
    for (int i = 0; i < 3; i++) wr_b(8'ha5 ^ 8'(i), 1'b0);
    host_u.stop();
    chk("active", 8'h00, {7'h00, active});
    for (int i = 0; i < 3; i++) chk("bank", 8'ha5 ^ 8'(i), bank[5 + i]);
  endtask
  task automatic t_read();
    host_u.start();
    wr_b(8'hd0, 1'b0);
    wr_b(8'h05, 1'b0);
    host_u.stop();
    chk("pointer", 8'h05, rd_addr);
    host_u.start();
    wr_b(8'hd1, 1'b0);
    for (int i = 0; i < 3; i++) rd_b(i < 2, 8'ha5 ^ 8'(i));
    host_u.stop();
  endtask
  task automatic t_nomatch();
    host_u.start();
    wr_b(8'hf0, 1'b1);
    chk("active", 8'h00, {7'h00, active});
    wr_b(8'h00, 1'b1);
    host_u.stop();
    chk("pointer", 8'h08, rd_addr);
  endtask
  task automatic t_strap();
    sel = 1'b1;
    host_u.start();
    wr_b(8'hd0, 1'b1);
    host_u.start();
    wr_b(8'hf0, 1'b0);
    wr_b(8'h06, 1'b0);
    host_u.start();
    wr_b(8'hf1, 1'b0);
    chk("active", 8'h01, {7'h00, active});
    rd_b(1'b0, 8'ha4);
    host_u.stop();
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // run takes about 7k cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    sel = 1'b0;
    foreach (bank[i]) bank[i] = 8'h00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_init();
    t_write();
    t_read();
    t_nomatch();
    t_strap();
    print_verdict();
  end
endmodule

// File: test/tsisp_checker.sv
/*
  tsisp_checker: port assertions for the i2c target port.
  assumes binding to tsisp_i2c_slave, one clk domain, rst synchronous.
*/
`timescale 1ns/1ps
module tsisp_checker (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 scl_i,
  input wire logic                 sda_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe,
  input wire logic                 address_select_pin,
  input wire logic                 reg_wr_en,
  input wire tsisp_pkg::tsisp_wr_t reg_wr,
  input wire logic [7:0]           reg_rd_addr,
  input wire logic [7:0]           reg_rd_data,
  input wire logic                 bus_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_sda_drive_low: assert property (sda_oe |-> !sda_o)
    else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved while scl high");
  a_drive_needs_match: assert property ($rose(sda_oe) |-> bus_active)
    else $error("sda driven without address match");
  a_ack_holds: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("driven bit too short");
  a_wr_single: assert property (reg_wr_en |=> !reg_wr_en)
    else $error("write pulse longer than one cycle");
  a_wr_ptr_step: assert property (reg_wr_en |=> reg_rd_addr == reg_wr.addr + 8'h01)
    else $error("pointer not advanced after write");
  a_wr_in_transfer: assert property (reg_wr_en |-> bus_active && !scl_i)
    else $error("write outside matched transfer");
  a_ptr_hold_idle: assert property (!bus_active ##1 !bus_active |-> $stable(reg_rd_addr))
    else $error("pointer moved while idle");
  a_end_scl_high: assert property ($fell(bus_active) |-> scl_i)
    else $error("transfer ended without start or stop");
endmodule

bind tsisp_i2c_slave tsisp_checker chk_u (.clk(clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
  .reg_wr_en(reg_wr_en), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
  .reg_rd_data(reg_rd_data), .bus_active(bus_active));

// File: test/tsisp_host_model.sv
/*
  tsisp_host_model: i2c controller model, 160 ns scl period.
  assumes sda is the resolved wire with pull-up; acts at falling clk edge.
*/
`timescale 1ns/1ps
module tsisp_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic     scl,
  output logic     sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // data moves in scl low, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    cyc(4);
    sda_pull = !b;
    cyc(12);
    scl = 1'b1;
    cyc(8);
    s = sda;
    cyc(8);
    scl = 1'b0;
  endtask
  // long low phase lets a held ack drop first
  task automatic start();
    cyc(4);
    sda_pull = 1'b0;
    cyc(12);
    scl = 1'b1;
    cyc(16);
    sda_pull = 1'b1;
    cyc(16);
    scl = 1'b0;
  endtask
  task automatic stop();
    cyc(4);
    sda_pull = 1'b1;
    cyc(12);
    scl = 1'b1;
    cyc(16);
    sda_pull = 1'b0;
    cyc(16);
  endtask
  // msb first, ack sampled on ninth bit
  task automatic wbyte(input logic [7:0] d, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], a);
    end
    bit_io(1'b1, a);
  endtask
  // ack all but the last byte read
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!more, s);
  endtask
endmodule
